// [hdl/wit_top.sv]
// watch and interval timer with apb registers and interrupt
//
// Chosen here: the APB slave port.
`default_nettype none
`include "wit_consts.svh"
module wit_top
  import wit_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic sub_clk_pin,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic watch_interrupt_request,
  output logic interval_interrupt_request
);
  wit_mode_t mode;
  logic [`WIT_DIV_W-1:0] div_cnt;
  logic div_tick;
  logic sub_rise;
  logic wclk_tick;
  logic [`WIT_CNT_W-1:0] cnt;
  logic watch_evt;
  logic interval_evt;
  logic sel_valid;
  logic [7:0] tap_ext;
  logic [`WIT_EVT_W-1:0] events;
  logic [`WIT_EVT_W-1:0] status;
  logic [`WIT_EVT_W-1:0] mask;
  logic [`WIT_EVT_W-1:0] next_status;
  logic [`WIT_EVT_W-1:0] stat_clr;
  logic access;
  logic done;
  logic wr;
  logic hit_mode;
  logic hit_stat;
  logic hit_mask;
  logic hit_cnt;
  logic hit_any;
  logic [31:0] next_prdata;

  wit_tick_if tk ();

  wit_pin_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin(sub_clk_pin),
    .rise(sub_rise)
  );

  wit_prescaler u_pre (
    .clk_sys(clk_sys),
    .rst(rst),
    .tk(tk)
  );

  // main clock divider by 128
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 7'h01;
  end
  assign div_tick = &div_cnt;

  // watch clock source
  assign wclk_tick = mode.clock_source_select ? sub_rise : div_tick; // [RULE1]
  assign tk.tick = wclk_tick;
  assign tk.enable = mode.watch_enable; // [RULE4]

  // interval tap selection
  assign tap_ext = {2'b00, tk.tap};
  assign sel_valid = (mode.interval_select <= `WIT_SEL_MAX); // [RULE2]
  assign interval_evt = sel_valid && tap_ext[mode.interval_select]; // [RULE9]

  // 5-bit watch counter
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      cnt <= '0;
    else if (!mode.watch_enable || !mode.counter_run)
      cnt <= '0; // [RULE3] [RULE7] [RULE8]
    else if (tk.carry)
      cnt <= cnt + 5'h01; // [RULE6]
  end
  assign watch_evt = mode.watch_enable && mode.counter_run && tk.carry && (&cnt); // [RULE6]

  // request pulses
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      watch_interrupt_request <= 1'b0;
      interval_interrupt_request <= 1'b0;
    end
    else
    begin
      watch_interrupt_request <= watch_evt;
      interval_interrupt_request <= interval_evt;
    end
  end

  // apb decode
  assign access = psel && penable;
  assign done = access && pready;
  assign wr = done && pwrite && pstrb[0];
  assign hit_mode = (paddr == {`WIT_MODE_IDX, 2'b00});
  assign hit_stat = (paddr == {`WIT_STAT_IDX, 2'b00});
  assign hit_mask = (paddr == {`WIT_MASK_IDX, 2'b00});
  assign hit_cnt = (paddr == {`WIT_CNT_IDX, 2'b00});
  assign hit_any = hit_mode || hit_stat || hit_mask || hit_cnt;

  // one wait state per access
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      pready <= 1'b0;
    else
      pready <= access && !pready;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      pslverr <= 1'b0;
    else
      pslverr <= access && !pready && !hit_any;
  end

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (hit_mode)
      next_prdata = {24'h00_0000, mode}; // [RULE12]
    else if (hit_stat)
      next_prdata = {30'h0000_0000, status};
    else if (hit_mask)
      next_prdata = {30'h0000_0000, mask};
    else if (hit_cnt)
      next_prdata = {27'h000_0000, cnt};
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (access && !pready && !pwrite)
      prdata <= next_prdata;
    else
      prdata <= 32'h0000_0000;
  end

  // mode register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      mode <= `WIT_MODE_RST; // [RULE5]
    else if (wr && hit_mode)
      mode <= pwdata[7:0] & `WIT_MODE_WMASK; // [RULE10] [RULE12]
  end

  // sticky status, set wins over clear
  assign events = {interval_evt, watch_evt};
  assign stat_clr = (wr && hit_stat) ? pwdata[`WIT_EVT_W-1:0] : 2'h0;
  assign next_status = (status & ~stat_clr) | events;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      status <= '0;
    else
      status <= next_status;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      mask <= '0;
    else if (wr && hit_mask)
      mask <= pwdata[`WIT_EVT_W-1:0];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(status & mask);
  end

  // checks
  a_mode_reset: assert property (@(posedge clk_sys) // [RULE5]
    $fell(rst) |-> mode == 8'h00)
    else $error("mode not zero after reset");

  a_mode_reserved: assert property (@(posedge clk_sys) disable iff (rst) // [RULE12]
    mode.reserved == 2'b00)
    else $error("reserved mode bits not zero");

  a_mode_write: assert property (@(posedge clk_sys) disable iff (rst) // [RULE10]
    (wr && hit_mode) |=> mode == ($past(pwdata[7:0]) & `WIT_MODE_WMASK))
    else $error("mode write not taken");

  a_unmapped_kept: assert property (@(posedge clk_sys) disable iff (rst)
    (done && !hit_any) |=> mode == $past(mode))
    else $error("unmapped access changed the mode");

  a_div_period: assert property (@(posedge clk_sys) disable iff (rst) // [RULE1]
    div_tick |-> ##128 div_tick)
    else $error("main divider period not 128");

  a_div_gap: assert property (@(posedge clk_sys) disable iff (rst) // [RULE1]
    div_tick |=> !div_tick [*8])
    else $error("main divider ticked too soon");

  a_src_main: assert property (@(posedge clk_sys) disable iff (rst) // [RULE1]
    (!mode.clock_source_select && mode.watch_enable && $past(mode.watch_enable)
     && $past(!mode.clock_source_select) && $past(div_cnt) != 7'h7f)
    |-> tk.count == $past(tk.count))
    else $error("prescaler moved off main divider tick");

  a_sub_src: assert property (@(posedge clk_sys) disable iff (rst) // [RULE1]
    (mode.clock_source_select && mode.watch_enable && $past(mode.watch_enable)
     && $past(mode.clock_source_select) && !$past(sub_rise))
    |-> tk.count == $past(tk.count))
    else $error("prescaler moved off sub clock edge");

  a_run_clear: assert property (@(posedge clk_sys) disable iff (rst) // [RULE3]
    !mode.counter_run |=> cnt == 5'h00)
    else $error("counter not cleared with run low");

  a_run_no_watch: assert property (@(posedge clk_sys) disable iff (rst) // [RULE3]
    !mode.counter_run |=> !watch_interrupt_request)
    else $error("watch request with counter stopped");

  a_enable_clear: assert property (@(posedge clk_sys) disable iff (rst) // [RULE4]
    !mode.watch_enable |=> (tk.count == 9'h000 && cnt == 5'h00))
    else $error("prescaler or counter not cleared when disabled");

  a_enable_no_tap: assert property (@(posedge clk_sys) disable iff (rst) // [RULE4]
    !mode.watch_enable |=> !interval_interrupt_request)
    else $error("interval request with timer stopped");

  a_count_step: assert property (@(posedge clk_sys) disable iff (rst) // [RULE7]
    (tk.carry && mode.counter_run && !(wr && hit_mode))
    |=> cnt == $past(cnt) + 5'h01)
    else $error("counter did not step on prescaler carry");

  a_cnt_hold: assert property (@(posedge clk_sys) disable iff (rst) // [RULE6]
    (mode.watch_enable && mode.counter_run && !tk.carry && !(wr && hit_mode))
    |=> cnt == $past(cnt))
    else $error("counter moved without prescaler carry");

  a_pre_kept: assert property (@(posedge clk_sys) disable iff (rst) // [RULE8]
    (mode.watch_enable && !mode.counter_run && wclk_tick && !(wr && hit_mode))
    |=> tk.count == $past(tk.count) + 9'h001)
    else $error("prescaler stopped with only run cleared");

  a_watch_ovf: assert property (@(posedge clk_sys) disable iff (rst) // [RULE6]
    (cnt == 5'h1f && tk.carry && mode.counter_run) |=> watch_interrupt_request)
    else $error("counter overflow gave no watch request");

  a_watch_only_ovf: assert property (@(posedge clk_sys) disable iff (rst) // [RULE6]
    watch_interrupt_request |-> $past(cnt) == 5'h1f)
    else $error("watch request without overflow");

  a_wreq_single: assert property (@(posedge clk_sys) disable iff (rst) // [RULE6]
    watch_interrupt_request |=> !watch_interrupt_request)
    else $error("watch request longer than one cycle");

  a_interval_tap0: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2] [RULE9]
    (mode.interval_select == 3'h0 && wclk_tick && mode.watch_enable
     && tk.count[3:0] == 4'hf) |=> interval_interrupt_request)
    else $error("shortest tap gave no interval request");

  a_tap_mid: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2]
    (interval_interrupt_request && $past(mode.interval_select) == 3'h2)
    |-> $past(tk.count[5:0]) == 6'h3f)
    else $error("middle tap fired off its period");

  a_interval_tap5: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2]
    (interval_interrupt_request && $past(mode.interval_select) == 3'h5)
    |-> $past(tk.count) == 9'h1ff)
    else $error("longest tap fired off its period");

  a_tap_tick: assert property (@(posedge clk_sys) disable iff (rst) // [RULE9]
    interval_interrupt_request |-> $past(wclk_tick))
    else $error("interval request without watch clock");

  a_prohibited: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2]
    (mode.interval_select > 3'h5) |-> !interval_evt)
    else $error("prohibited interval code raised a request");

  a_status_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (wr && hit_stat && pwdata[1] && !events[1]) |=> !status[1])
    else $error("interval status not cleared by write");

  a_status_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (events == 2'h0 && !(wr && hit_stat)) |=> status == $past(status))
    else $error("status changed without event or clear");

  a_mask_write: assert property (@(posedge clk_sys) disable iff (rst)
    (wr && hit_mask) |=> mask == $past(pwdata[`WIT_EVT_W-1:0]))
    else $error("mask write not taken");

  a_irq_low: assert property (@(posedge clk_sys) disable iff (rst)
    ((status & mask) == 2'h0) |=> !irq)
    else $error("irq high with no unmasked status");

  a_pready_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    pready |=> !pready)
    else $error("apb ready longer than one cycle");

  a_slverr_ready: assert property (@(posedge clk_sys) disable iff (rst)
    pslverr |-> pready)
    else $error("apb error without ready");

  a_rdata_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data outside the answer cycle");

  a_status_set_wins: assert property (@(posedge clk_sys) disable iff (rst)
    (events != 2'h0) |=> ((status & $past(events)) == $past(events)))
    else $error("status event lost");

  a_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
    ((status & mask) != 2'h0) |=> irq)
    else $error("irq low with unmasked status");

  a_apb_wait: assert property (@(posedge clk_sys) disable iff (rst)
    (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");

  c_watch_ovf: cover property (@(posedge clk_sys) disable iff (rst)
    watch_interrupt_request);
  c_both_events: cover property (@(posedge clk_sys) disable iff (rst)
    watch_interrupt_request && interval_interrupt_request);
  c_sub_clock: cover property (@(posedge clk_sys) disable iff (rst)
    mode.clock_source_select && interval_interrupt_request);
  c_irq: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(irq));
  c_pre_kept: cover property (@(posedge clk_sys) disable iff (rst)
    mode.watch_enable && !mode.counter_run && tk.carry);
endmodule : wit_top
`default_nettype wire

// [include/wit_consts.svh]
// offsets, field positions, reset values and counts of the watch and interval timer
// Function
// RULE1 - the watch clock is the system clock divided by 2^7 when the source bit is 0, else the sub clock.
// RULE2 - interval codes 0 to 5 select prescaler periods of 2^4 to 2^9 watch clocks; other codes give nothing.
// RULE3 - counter run at 0 stops and clears the 5-bit counter; at 1 it may count.
// RULE4 - watch enable at 0 stops and clears prescaler and counter; at 1 the timer operates.
// RULE5 - reset loads the mode register with all zeros.
// RULE6 - the counter counts watch clock / 2^9 pulses and each overflow raises the watch request.
// RULE7 - enable and run both set make the watch count; both clear stops and clears the counter.
// RULE8 - clearing only run clears the counter while the prescaler keeps running.
// RULE9 - the interval request repeats at the selected tap and runs together with the watch.
// RULE10 - the hardware is one 9-bit prescaler and one 5-bit counter under one 8-bit mode register.
// RULE11 - software picks the sub clock when the main clock cannot give an exact half second.
// RULE12 - mode bits 3 and 2 read as zero and ignore writes.
`ifndef WIT_CONSTS_SVH
`define WIT_CONSTS_SVH
`define WIT_ADDR_W 18
`define WIT_MODE_IDX 16'hff4a
`define WIT_STAT_IDX 16'hff4b
`define WIT_MASK_IDX 16'hff4c
`define WIT_CNT_IDX 16'hff4d
`define WIT_MODE_RST 8'h00
`define WIT_MODE_WMASK 8'hf3
`define WIT_DIV_W 7
`define WIT_PRE_W 9
`define WIT_CNT_W 5
`define WIT_TAP_MIN 4
`define WIT_TAP_N 6
`define WIT_SEL_MAX 3'h5
`define WIT_EVT_W 2
`define WIT_EVT_WATCH 0
`define WIT_EVT_INTV 1
`endif

// [include/wit_pkg.sv]
// types of the watch and interval timer
`default_nettype none
package wit_pkg;
  typedef struct packed {
    logic clock_source_select;
    logic [2:0] interval_select;
    logic [1:0] reserved;
    logic counter_run;
    logic watch_enable;
  } wit_mode_t;
endpackage : wit_pkg
`default_nettype wire

// [include/wit_tick_if.sv]
// prescaler link between the timer core and its prescaler
`default_nettype none
interface wit_tick_if;
  logic tick;
  logic enable;
  logic [8:0] count;
  logic carry;
  logic [5:0] tap;
  modport pre (input tick, input enable, output count, output carry, output tap);
  modport user (output tick, output enable, input count, input carry, input tap);
endinterface : wit_tick_if
`default_nettype wire

// [hdl/wit_pin_sync.sv]
// three-stage pin synchroniser with rising edge pulse
`default_nettype none
module wit_pin_sync (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pin,
  output logic rise
);
  logic s1;
  logic s2;
  logic s3;
  logic stable;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // level accepted once stages two and three agree
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      stable <= 1'b0;
    else if (s2 == s3)
      stable <= s3;
  end
  assign rise = (s2 == s3) && s3 && !stable;
  a_rise_once: assert property (@(posedge clk_sys) disable iff (rst)
    rise |=> !rise)
    else $error("sub clock edge pulse longer than one cycle");
endmodule : wit_pin_sync
`default_nettype wire

// [hdl/wit_prescaler.sv]
// 9-bit watch prescaler with interval taps
`default_nettype none
`include "wit_consts.svh"
module wit_prescaler (
  input wire logic clk_sys,
  input wire logic rst,
  wit_tick_if.pre tk
);
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      tk.count <= '0;
    else if (!tk.enable)
      tk.count <= '0; // [RULE4]
    else if (tk.tick)
      tk.count <= tk.count + 9'h001; // [RULE10]
  end
  // carry every 2^9 watch clocks
  assign tk.carry = tk.enable && tk.tick && (&tk.count); // [RULE6]
  genvar i;
  generate
    for (i = 0; i < `WIT_TAP_N; i++)
    begin : g_tap
      assign tk.tap[i] = tk.enable && tk.tick && (&tk.count[`WIT_TAP_MIN+i-1:0]); // [RULE2]
    end
  endgenerate
  a_pre_carry: assert property (@(posedge clk_sys) disable iff (rst) // [RULE10]
    tk.carry |=> tk.count == 9'h000)
    else $error("prescaler did not wrap on carry");
  a_pre_idle: assert property (@(posedge clk_sys) disable iff (rst) // [RULE4]
    (tk.enable && !tk.tick) |=> tk.count == $past(tk.count) || !tk.enable)
    else $error("prescaler moved without a watch clock");
endmodule : wit_prescaler
`default_nettype wire

// [verif/tb.sv]
// self-checking bench of the watch and interval timer
`default_nettype none
`include "wit_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [17:0] a_mode = {`WIT_MODE_IDX, 2'b00};
  localparam logic [17:0] a_stat = {`WIT_STAT_IDX, 2'b00};
  localparam logic [17:0] a_mask = {`WIT_MASK_IDX, 2'b00};
  localparam logic [17:0] a_cnt = {`WIT_CNT_IDX, 2'b00};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic sub_clk_pin = 1'b0;
  logic sub_on = 1'b0;
  logic [2:0] sc = 3'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, wreq, ireq;
  logic [32:0] q_rd[$];
  int q_gap[$];
  int fail_count = 0;
  int tests_run = 0;
  int gap = 0;
  int cyc = 0;
  int n;
  int n_wreq = 0;
  logic [7:0] r = 8'h19;
  wit_top wit_top_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .sub_clk_pin(sub_clk_pin), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .watch_interrupt_request(wreq), .interval_interrupt_request(ireq));
  always #5 clk_sys = ~clk_sys;
  // sub clock of eight system clocks per period
  always @(posedge clk_sys)
  begin
    sc <= sc + 3'h1;
    sub_clk_pin <= sub_on & sc[2];
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // apb access; expected answer noted for the watcher
  task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d,
    input logic [7:0] e, input logic err);
    q_rd.push_back({err, 24'h0, e});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= 4'h1;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic wait_iv;
    do @(posedge clk_sys); while (ireq !== 1'b1);
  endtask : wait_iv
  task automatic wait_n(input int c);
    repeat (c) @(posedge clk_sys);
  endtask : wait_n
  // watcher: apb answers and interval gaps
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc > 90000)
    begin
      fail_count++;
      print_verdict();
    end
    else
    begin
      if (wreq === 1'b1)
        n_wreq++;
      if (pready === 1'b1 && q_rd.size() > 0)
        check("apb answer", {pslverr, prdata}, q_rd.pop_front());
      if (ireq === 1'b1)
      begin
        if (q_gap.size() > 0)
          check("interval gap", 33'(gap), 33'(q_gap.pop_front()));
        gap = 1;
      end
      else
        gap++;
    end
  end
  initial
  begin
    wait_n(10);
    rst <= 1'b0;
    @(posedge clk_sys);
    apb(0, a_mode, 8'h0, 8'h00, 0);
    apb(0, a_cnt + 18'h4, 8'h0, 8'h00, 1);
    repeat (4)
    begin
      r = lfsr(r);
      apb(1, a_mode, r & 8'hfc, 8'h00, 0);
      apb(0, a_mode, 8'h0, r & 8'hf0, 0);
    end
    apb(1, a_mode, 8'h0c, 8'h00, 0);
    apb(0, a_mode, 8'h0, 8'h00, 0);
    $display("registers done");
    apb(1, a_mode, 8'h01, 8'h00, 0);
    wait_iv();
    @(posedge clk_sys);
    q_gap.push_back(2048);
    wait_iv();
    sub_on <= 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      apb(1, a_mode, 8'h81 | 8'(k << 4), 8'h00, 0);
      wait_iv();
      @(posedge clk_sys);
      q_gap.push_back((16 << k) * 8);
      wait_iv();
    end
    for (int k = 6; k < 8; k++)
    begin
      apb(1, a_mode, 8'h81 | 8'(k << 4), 8'h00, 0);
      n = 0;
      repeat (5000)
      begin
        @(posedge clk_sys);
        n += int'(ireq === 1'b1);
      end
      check("unused code pulses", 33'(n), 33'(0));
    end
    $display("interval done");
    // prescaler cleared first so the first carry comes a known time later
    apb(1, a_mode, 8'h80, 8'h00, 0);
    apb(1, a_mode, 8'h83, 8'h00, 0);
    wait_n(4800);
    apb(0, a_cnt, 8'h0, 8'h01, 0);
    apb(1, a_mode, 8'h82, 8'h00, 0);
    apb(0, a_cnt, 8'h0, 8'h00, 0);
    apb(1, a_mode, 8'h83, 8'h00, 0);
    wait_n(4800);
    apb(1, a_mode, 8'h81, 8'h00, 0);
    apb(0, a_cnt, 8'h0, 8'h00, 0);
    // kept prescaler carries well before a fresh one would
    apb(1, a_mode, 8'h83, 8'h00, 0);
    wait_n(3600);
    apb(0, a_cnt, 8'h0, 8'h01, 0);
    wait_iv();
    @(posedge clk_sys);
    q_gap.push_back(128);
    wait_iv();
    apb(1, a_mode, 8'h00, 8'h00, 0);
    $display("counter done");
    apb(0, a_stat, 8'h0, 8'h02, 0);
    check("irq masked", 33'(irq), 33'(0));
    apb(1, a_mask, 8'h02, 8'h00, 0);
    wait_n(2);
    check("irq raised", 33'(irq), 33'(1));
    apb(1, a_stat, 8'h02, 8'h00, 0);
    wait_n(2);
    check("irq cleared", 33'(irq), 33'(0));
    apb(0, a_stat, 8'h0, 8'h00, 0);
    $display("interrupt done");
    wait_n(4);
    check("watch requests", 33'(n_wreq), 33'(0));
    print_verdict();
  end
endmodule : tb
`default_nettype wire
